/* File: uic_ctrl.sv */
module uic_ctrl
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // register port
   input  wire logic [2:0]           reg_addr,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   // status from the datapath
   input  wire logic [7:0]           line_status_reg,
   input  wire logic [7:0]           modem_status_reg,
   input  wire logic [uic_pkg::UIC_LVL_W-1:0] rx_level,
   input  wire logic                 rx_push,
   input  wire logic                 tx_empty,
   input  wire logic                 bit_tick,
   input  wire logic [1:0]           size_sel,
   input  wire logic [7:0]           rx_data,
   input  wire logic                 tx_line_in,
   // controls to the datapath
   output logic                      fifo_en,
   output logic                      rx_fifo_rst,
   output logic                      tx_fifo_rst,
   output logic                      rx_pop,
   output logic                      thr_write,
   output logic      [7:0]           thr_data,
   output logic                      dl_low_wr,
   output logic                      dl_high_wr,
   output logic      [3:0]           data_bits,
   output logic                      stop_half,
   output logic                      stop_two,
   output logic                      parity_en,
   output logic                      parity_even,
   output logic                      parity_forced,
   output logic                      parity_force_val,
   output logic      [uic_pkg::UIC_LVL_W-1:0] trig_level,
   output logic                      tx_line_out,
   // interrupt
   output logic                      irq
);
   import uic_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0] line_format_reg,     line_format_next;
   logic [7:0] interrupt_enable_reg, interrupt_enable_next;
   logic       fifo_en_reg,         fifo_en_next;
   logic [1:0] trig_sel_reg,        trig_sel_next;
   logic       rxrst_reg,           rxrst_next;
   logic       txrst_reg,           txrst_next;
   logic       transmit_ready_irq_reg, transmit_ready_irq_next;
   logic       tx_empty_d_reg;
   logic [7:0] rdata_reg,           rdata_next;
   logic       receive_ready_irq;
   logic       ls_irq;
   logic       ms_irq;
   logic       tmo_irq;
   logic       tmo_seen_reg,        tmo_seen_next;
   logic       tmo_hit;
   logic [3:0] isr_id;
   logic [7:0] interrupt_status_reg;
   logic       dlab;
   logic       rd_data_sel;
   logic       rd_istat;
   logic [3:0] frame_bits;

   // ---------------------------------------------------------------
   // trigger level lookup
   // ---------------------------------------------------------------
   function automatic logic [UIC_LVL_W-1:0] trig_lookup(input logic [1:0] sz,
                                                       input logic [1:0] sel);
      logic [UIC_LVL_W-1:0] base;
      base = 8'h00;
      case (sel)
         2'h0: base = 8'h01;
         2'h1: base = 8'h04;
         2'h2: base = 8'h08;
         default: base = 8'h0e;
      endcase
      // size 00 is the base column, larger sizes double it; col 0 is 1,2,4,8
      if (sel == 2'h0)
         trig_lookup = UIC_LVL_W'(8'h01 << sz);
      else
         trig_lookup = UIC_LVL_W'(base << sz);
   endfunction : trig_lookup

   assign dlab        = line_format_reg[UIC_LF_DLAB];
   assign rd_data_sel = reg_rd && reg_addr == UIC_OFS_DATA && !dlab;
   assign rd_istat    = reg_rd && reg_addr == UIC_OFS_ISTAT;

   // ---------------------------------------------------------------
   // interrupt sources
   // ---------------------------------------------------------------
   // status flags are sticky in the datapath and clear on their own read
   assign ls_irq = |line_status_reg[4:1];
   assign ms_irq = |modem_status_reg[3:0];
   assign trig_level = trig_lookup(size_sel, trig_sel_reg);
   assign receive_ready_irq = fifo_en_reg ? (rx_level >= trig_level)
                                          : (rx_level != '0);
   assign frame_bits = 4'(data_bits + 4'h2 + {3'h0, parity_en}
                          + {3'h0, stop_two | stop_half});

   uic_timeout u_tmo
   (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .bit_tick   (bit_tick),
      .frame_bits (frame_bits),
      .restart    (rx_push || rd_data_sel),
      .run        (rx_level != '0 && fifo_en_reg),
      .expired    (tmo_hit)
   );

   // timeout latched until the host reads the receive holding register or the receive fifo empties
   assign tmo_irq = tmo_seen_reg;

   // ---------------------------------------------------------------
   // priority encoder
   // ---------------------------------------------------------------
   always_comb
   begin
      isr_id = UIC_ID_NONE;
      if (ls_irq && interrupt_enable_reg[UIC_IE_LS])
         isr_id = UIC_ID_LS;
      else if (tmo_irq && interrupt_enable_reg[UIC_IE_RX])
         isr_id = UIC_ID_TMO;
      else if (receive_ready_irq && interrupt_enable_reg[UIC_IE_RX])
         isr_id = UIC_ID_RX;
      else if (transmit_ready_irq_reg && interrupt_enable_reg[UIC_IE_TX])
         isr_id = UIC_ID_TX;
      else if (ms_irq && interrupt_enable_reg[UIC_IE_MS])
         isr_id = UIC_ID_MS;
   end

   assign interrupt_status_reg = {fifo_en_reg, fifo_en_reg, 2'h0, isr_id};
   assign irq = (isr_id != UIC_ID_NONE);

   // ---------------------------------------------------------------
   // register next-state
   // ---------------------------------------------------------------
   always_comb
   begin
      line_format_next        = line_format_reg;
      interrupt_enable_next   = interrupt_enable_reg;
      fifo_en_next            = fifo_en_reg;
      trig_sel_next           = trig_sel_reg;
      rxrst_next              = 1'b0;      // self clearing pulses
      txrst_next              = 1'b0;
      transmit_ready_irq_next = transmit_ready_irq_reg;
      tmo_seen_next           = tmo_seen_reg;
      rdata_next              = rdata_reg;
      // clears first, so a same-cycle set below wins; the empty-fifo time-out clear comes last and wins
      if (rd_istat && isr_id == UIC_ID_TX)
         transmit_ready_irq_next = 1'b0;
      if (reg_wr && reg_addr == UIC_OFS_DATA && !dlab)
         transmit_ready_irq_next = 1'b0;
      if (tx_empty && !tx_empty_d_reg)
         transmit_ready_irq_next = 1'b1;
      if (rd_data_sel)
         tmo_seen_next = 1'b0;
      if (tmo_hit)
         tmo_seen_next = 1'b1;
      if (rx_level == '0)
         tmo_seen_next = 1'b0;
      if (reg_wr)
      begin
         if (reg_addr == UIC_OFS_LFMT)
            line_format_next = reg_wdata;
         else if (reg_addr == UIC_OFS_IEN && !dlab)
            interrupt_enable_next = {4'h0, reg_wdata[3:0]};
         else if (reg_addr == UIC_OFS_ISTAT)
         begin
            fifo_en_next = reg_wdata[UIC_FC_EN];
            if (reg_wdata[UIC_FC_EN])
            begin
               trig_sel_next = reg_wdata[7:6];
               rxrst_next    = reg_wdata[UIC_FC_RXRST];
               txrst_next    = reg_wdata[UIC_FC_TXRST];
            end
         end
      end
      // read mux, registered data output
      if (reg_rd)
      begin
         if (reg_addr == UIC_OFS_ISTAT)
            rdata_next = interrupt_status_reg;
         else if (reg_addr == UIC_OFS_LFMT)
            rdata_next = line_format_reg;
         else if (reg_addr == UIC_OFS_IEN && !dlab)
            rdata_next = interrupt_enable_reg;
         else if (reg_addr == UIC_OFS_DATA && !dlab)
            rdata_next = rx_data;
         else if (reg_addr == UIC_OFS_LSTAT)
            rdata_next = line_status_reg;
         else if (reg_addr == UIC_OFS_MSTAT)
            rdata_next = modem_status_reg;
         else
            rdata_next = 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // register update
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         line_format_reg        <= UIC_LFMT_RST;
         interrupt_enable_reg   <= UIC_IEN_RST;
         fifo_en_reg            <= 1'b0;
         trig_sel_reg           <= UIC_TRIG_RST;
         rxrst_reg              <= 1'b0;
         txrst_reg              <= 1'b0;
         transmit_ready_irq_reg <= 1'b0;
         tx_empty_d_reg         <= 1'b1;
         tmo_seen_reg           <= 1'b0;
         rdata_reg              <= 8'h00;
      end
      else
      begin
         line_format_reg        <= line_format_next;
         interrupt_enable_reg   <= interrupt_enable_next;
         fifo_en_reg            <= fifo_en_next;
         trig_sel_reg           <= trig_sel_next;
         rxrst_reg              <= rxrst_next;
         txrst_reg              <= txrst_next;
         transmit_ready_irq_reg <= transmit_ready_irq_next;
         tx_empty_d_reg         <= tx_empty;
         tmo_seen_reg           <= tmo_seen_next;
         rdata_reg              <= rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs to the datapath
   // ---------------------------------------------------------------
   assign reg_rdata        = rdata_reg;
   assign fifo_en          = fifo_en_reg;
   assign rx_fifo_rst      = rxrst_reg;
   assign tx_fifo_rst      = txrst_reg;
   assign rx_pop           = rd_data_sel;
   assign thr_write        = reg_wr && reg_addr == UIC_OFS_DATA && !dlab;
   assign thr_data         = reg_wdata;
   assign dl_low_wr        = reg_wr && reg_addr == UIC_OFS_DATA && dlab;
   assign dl_high_wr       = reg_wr && reg_addr == UIC_OFS_IEN && dlab;
   assign data_bits        = 4'h5 + {2'h0, line_format_reg[1:0]};
   assign stop_half        = line_format_reg[UIC_LF_STOP] && line_format_reg[1:0] == 2'h0;
   assign stop_two         = line_format_reg[UIC_LF_STOP] && line_format_reg[1:0] != 2'h0;
   assign parity_en        = line_format_reg[UIC_LF_PEN];
   assign parity_even      = line_format_reg[UIC_LF_EVEN];
   assign parity_forced    = parity_en && line_format_reg[UIC_LF_FORCE];
   assign parity_force_val = !line_format_reg[UIC_LF_EVEN];
   assign tx_line_out      = tx_line_in && !line_format_reg[UIC_LF_BREAK];
endmodule : uic_ctrl

/* File: uic_pkg.sv */
// Behaviour
// - line-status irq from line status bits 1-4; modem irq from modem bits 0-3
// - receive time-out irq after four character times plus twelve bit times
// - transmit-ready irq raised when the transmit fifo becomes empty
// - transmit-ready irq cleared by an interrupt status read that reports it, or a transmit holding write
// - line-status irq cleared by a line status register read
// - receive data irq holds while fill count is at or above trigger level, or non-zero with fifos off
// - receive time-out irq cleared by a receive holding register read
// - modem-status irq cleared by a modem status register read
// - status bits 3:0 report only the highest priority pending source
// - status bit 0 is low while pending, high when idle and after reset
// - status bits 7:6 mirror fifo enable; bits 5:4 read zero
// - fifo control bit 0 enables fifos; other bits ignored unless it is set
// - fifo control bit 1 resets receive fifo pointers, self clearing
// - fifo control bit 2 resets transmit fifo pointers, self clearing
// - trigger level from fifo control bits 7:6 and the size-select field
// - line format bits 1:0 select 5 to 8 data bits
// - line format bit 2 selects one, one and a half, or two stop bits
// - line format bit 3 enables parity generation and checking
// - line format bit 4 selects odd (0) or even (1) parity
// - line format bit 5 forces parity high when bit 4 is 0, else low
// - line format bit 6 forces the serial output low until cleared
// - line format bit 7 maps writes at the two lowest offsets to the divisor bytes; reads there return zero
// - each irq source reaches the output only with its enable bit set
package uic_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [2:0] UIC_OFS_DATA   = 3'h0;
   localparam logic [2:0] UIC_OFS_IEN    = 3'h1;
   localparam logic [2:0] UIC_OFS_ISTAT  = 3'h2;
   localparam logic [2:0] UIC_OFS_LFMT   = 3'h3;
   localparam logic [2:0] UIC_OFS_LSTAT  = 3'h5;
   localparam logic [2:0] UIC_OFS_MSTAT  = 3'h6;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int UIC_FC_EN      = 0;
   localparam int UIC_FC_RXRST   = 1;
   localparam int UIC_FC_TXRST   = 2;
   localparam int UIC_LF_STOP    = 2;
   localparam int UIC_LF_PEN     = 3;
   localparam int UIC_LF_EVEN    = 4;
   localparam int UIC_LF_FORCE   = 5;
   localparam int UIC_LF_BREAK   = 6;
   localparam int UIC_LF_DLAB    = 7;
   localparam int UIC_IE_RX      = 0;
   localparam int UIC_IE_TX      = 1;
   localparam int UIC_IE_LS      = 2;
   localparam int UIC_IE_MS      = 3;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] UIC_LFMT_RST  = 8'h00;
   localparam logic [7:0] UIC_IEN_RST   = 8'h00;
   localparam logic [1:0] UIC_TRIG_RST  = 2'h0;
   // ---------------------------------------------------------------
   // interrupt codes, highest priority first
   // ---------------------------------------------------------------
   localparam logic [3:0] UIC_ID_LS     = 4'h6;
   localparam logic [3:0] UIC_ID_TMO    = 4'hc;
   localparam logic [3:0] UIC_ID_RX     = 4'h4;
   localparam logic [3:0] UIC_ID_TX     = 4'h2;
   localparam logic [3:0] UIC_ID_MS     = 4'h0;
   localparam logic [3:0] UIC_ID_NONE   = 4'h1;
   // ---------------------------------------------------------------
   // timing: time-out is 4 characters plus 12 bit times
   // ---------------------------------------------------------------
   localparam int UIC_TMO_CHARS  = 4;
   localparam int UIC_TMO_BITS   = 12;
   localparam int UIC_LVL_W      = 8;
   localparam int UIC_TMO_W      = 16;
endpackage : uic_pkg

/* File: uic_timeout.sv */
module uic_timeout
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // control
   input  wire logic                 bit_tick,
   input  wire logic [3:0]           frame_bits,
   input  wire logic                 restart,
   input  wire logic                 run,
   // result
   output logic                      expired
);
   import uic_pkg::*;
   logic [UIC_TMO_W-1:0] cnt_reg;
   logic [UIC_TMO_W-1:0] cnt_next;
   logic                 exp_reg;
   logic                 exp_next;
   logic [UIC_TMO_W-1:0] limit;

   // limit in bit times; frame length varies with the line format
   assign limit = UIC_TMO_W'(UIC_TMO_CHARS) * UIC_TMO_W'(frame_bits)
                  + UIC_TMO_W'(UIC_TMO_BITS);

   // -------------------------------------------------------------
   // bit-time counter
   // -------------------------------------------------------------
   always_comb
   begin
      cnt_next = cnt_reg;
      exp_next = 1'b0;
      if (restart || !run)
      begin
         cnt_next = '0;
      end
      else if (bit_tick && cnt_reg < limit)
      begin
         cnt_next = cnt_reg + 1'b1;
      end
      // pulse once at the limit, so a receive read can clear the latched flag
      exp_next = run && !restart && bit_tick && (cnt_reg + 1'b1 == limit);
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_reg <= '0;
         exp_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
      end
   end

   assign expired = exp_reg;
endmodule : uic_timeout

/* File: uic_dp_model.sv */
module uic_dp_model
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // host side activity seen by the datapath
   input  wire logic [2:0] reg_addr,
   input  wire logic reg_rd,
   input  wire logic rx_pop,
   input  wire logic rx_fifo_rst,
   // bench commands
   input  wire logic ls_set,
   input  wire logic ms_set,
   input  wire logic push_req,
   // status toward the control block
   output logic [7:0] line_status_reg,
   output logic [7:0] modem_status_reg,
   output logic [uic_pkg::UIC_LVL_W-1:0] rx_level,
   output logic rx_push,
   output logic bit_tick,
   output logic [7:0] rx_data,
   output logic tx_line_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import uic_pkg::*;
   logic [1:0] div_reg;
   // defined levels before the first edge
   initial
   begin
      {line_status_reg, modem_status_reg, rx_level, rx_push, bit_tick, rx_data} = '0;
      {div_reg, tx_line_in} = 3'h0;
   end
   // a bit time is four clocks; the serial output toggles so a stuck output shows
   always @(posedge clk_sys)
   begin
      div_reg <= rst ? 2'h0 : div_reg + 2'h1;
      bit_tick <= !rst && div_reg == 2'h3;
      tx_line_in <= ~tx_line_in;
      rx_push <= !rst && push_req;
      rx_data <= rx_data + 8'h01;
      if (rst || (reg_rd && reg_addr == UIC_OFS_LSTAT)) line_status_reg <= 8'h00;
      else if (ls_set) line_status_reg[1] <= 1'b1;
      if (rst || (reg_rd && reg_addr == UIC_OFS_MSTAT)) modem_status_reg <= 8'h00;
      else if (ms_set) modem_status_reg[0] <= 1'b1;
      if (rst || rx_fifo_rst) rx_level <= '0;
      else rx_level <= rx_level + {7'h0, push_req} - {7'h0, rx_pop};
   end
endmodule : uic_dp_model

/* File: uic_ctrl_properties.sv */
module uic_ctrl_properties
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic reg_wr,
   input  wire logic reg_rd,
   input  wire logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   // datapath side
   input  wire logic [1:0] size_sel,
   input  wire logic tx_line_in,
   input  wire logic fifo_en,
   input  wire logic rx_fifo_rst,
   input  wire logic tx_fifo_rst,
   input  wire logic rx_pop,
   input  wire logic thr_write,
   input  wire logic dl_low_wr,
   input  wire logic dl_high_wr,
   input  wire logic [7:0] thr_data,
   input  wire logic [3:0] data_bits,
   input  wire logic stop_half,
   input  wire logic stop_two,
   input  wire logic parity_en,
   input  wire logic parity_even,
   input  wire logic parity_forced,
   input  wire logic parity_force_val,
   input  wire logic [uic_pkg::UIC_LVL_W-1:0] trig_level,
   input  wire logic tx_line_out,
   input  wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import uic_pkg::*;
   logic [7:0] lf_reg;
   logic [1:0] tsel_reg;
   logic [7:0] base;
   wire st_rd = reg_rd && reg_addr == UIC_OFS_ISTAT;
   wire fc_wr = reg_wr && reg_addr == UIC_OFS_ISTAT;
   // shadow of the format byte and trigger select, seen from the host writes
   always_ff @(posedge clk_sys)
   begin
      if (rst) lf_reg <= UIC_LFMT_RST;
      else if (reg_wr && reg_addr == UIC_OFS_LFMT) lf_reg <= reg_wdata;
      if (rst) tsel_reg <= UIC_TRIG_RST;
      else if (fc_wr && reg_wdata[0]) tsel_reg <= reg_wdata[7:6];
   end
   assign base = tsel_reg == 2'h0 ? 8'h01 : tsel_reg == 2'h1 ? 8'h04 :
                 tsel_reg == 2'h2 ? 8'h08 : 8'h0e;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // status byte, fifo control and line format
   // ------------------------------------------------------------
   pending_bit_a: assert property (st_rd |=> reg_rdata[0] == !$past(irq))
      else $error("status bit 0 disagrees with irq");
   fifo_bits_a: assert property (st_rd |=> reg_rdata[7:4] == {{2{$past(fifo_en)}}, 2'b00})
      else $error("status bits 7:4 wrong");
   fifo_on_a: assert property (fc_wr && reg_wdata[0] |=> fifo_en)
      else $error("fifo enable not taken");
   fc_refused_a: assert property (fc_wr && !reg_wdata[0] |=> !fifo_en && !rx_fifo_rst && !tx_fifo_rst)
      else $error("fifo control taken without enable");
   rx_clear_a: assert property (fc_wr && reg_wdata[0] && reg_wdata[1] |=> rx_fifo_rst ##1 !rx_fifo_rst)
      else $error("rx fifo reset pulse wrong");
   tx_clear_a: assert property (fc_wr && reg_wdata[0] && reg_wdata[2] |=> tx_fifo_rst ##1 !tx_fifo_rst)
      else $error("tx fifo reset pulse wrong");
   trig_table_a: assert property (trig_level == (base << size_sel))
      else $error("trigger level wrong");
   char_len_a: assert property (data_bits == 4'h5 + {2'b00, lf_reg[1:0]})
      else $error("data bits wrong");
   stop_len_a: assert property ({stop_half, stop_two} == {lf_reg[2] && lf_reg[1:0] == 2'h0, lf_reg[2] && lf_reg[1:0] != 2'h0})
      else $error("stop bits wrong");
   parity_on_a: assert property (parity_en == lf_reg[3])
      else $error("parity enable wrong");
   parity_kind_a: assert property (lf_reg[3] && !lf_reg[5] |-> parity_even == lf_reg[4])
      else $error("parity sense wrong");
   parity_force_a: assert property (lf_reg[3] && lf_reg[5] |-> parity_forced && parity_force_val == !lf_reg[4])
      else $error("forced parity wrong");
   break_out_a: assert property (tx_line_out == (tx_line_in && !lf_reg[6]))
      else $error("break output wrong");
   latch_map_a: assert property (reg_wr && reg_addr == UIC_OFS_DATA |-> dl_low_wr == lf_reg[7] && thr_write == !lf_reg[7])
      else $error("offset 0 write mapped wrong");
   pop_map_a: assert property (reg_rd && reg_addr == UIC_OFS_DATA |-> rx_pop == !lf_reg[7])
      else $error("offset 0 read mapped wrong");
   latch_high_a: assert property (reg_wr && reg_addr == UIC_OFS_IEN |->
      dl_high_wr == lf_reg[7] && thr_data == reg_wdata)
      else $error("offset 1 write mapped wrong");
   cover property (rx_fifo_rst);
   cover property (st_rd && irq);
   cover property (tx_line_in && !tx_line_out);
   cover property (dl_low_wr);
endmodule : uic_ctrl_properties
bind uic_ctrl uic_ctrl_properties u_props (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .size_sel, .tx_line_in, .fifo_en, .rx_fifo_rst, .tx_fifo_rst,
   .rx_pop, .thr_write, .dl_low_wr, .dl_high_wr, .thr_data, .data_bits,
   .stop_half, .stop_two, .parity_en,
   .parity_even, .parity_forced, .parity_force_val, .trig_level, .tx_line_out, .irq);

/* File: uic_ctrl_tb.sv */
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
   $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module uic_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import uic_pkg::*;
   logic clk_sys, rst, reg_wr, reg_rd, tx_empty, ls_set, ms_set, push_req;
   logic rx_push, bit_tick, tx_line_in, tx_line_out, rx_fifo_rst, rx_pop, irq;
   logic [2:0] reg_addr;
   logic [1:0] size_sel;
   logic [7:0] reg_wdata, reg_rdata, line_status_reg, modem_status_reg, rx_data, d, v;
   logic [UIC_LVL_W-1:0] rx_level, trig_level;
   logic m_fen, m_ls, m_ms, m_tx, m_tmo;
   logic [3:0] m_ien;
   int err_total, compares, seed, m_lvl, m_trig;
   int tbl [16] = '{1, 4, 8, 14, 2, 8, 16, 28, 4, 16, 32, 56, 8, 32, 64, 112};
   uic_ctrl dut (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .line_status_reg, .modem_status_reg, .rx_level, .rx_push, .tx_empty, .bit_tick,
      .size_sel, .rx_data, .tx_line_in, .fifo_en(), .rx_fifo_rst, .tx_fifo_rst(), .rx_pop,
      .thr_write(), .thr_data(), .dl_low_wr(), .dl_high_wr(), .data_bits(), .stop_half(),
      .stop_two(), .parity_en(), .parity_even(), .parity_forced(), .parity_force_val(),
      .trig_level, .tx_line_out, .irq);
   uic_dp_model u_dp (.clk_sys, .rst, .reg_addr, .reg_rd, .rx_pop, .rx_fifo_rst, .ls_set,
      .ms_set, .push_req, .line_status_reg, .modem_status_reg, .rx_level, .rx_push,
      .bit_tick, .rx_data, .tx_line_in);
   // ------------------------------------------------------------
   // host cycles; each ends just after an edge so outputs have settled
   // ------------------------------------------------------------
   task automatic wr(input logic [2:0] a, input logic [7:0] w);
      @(posedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} <= {a, w, 1'b1};
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge clk_sys);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      #1 d = reg_rdata;
   endtask : rd
   // one-cycle command to the datapath model: 0 line flag, 1 modem flag, 2 push
   task automatic cmd(input int k);
      @(posedge clk_sys);
      {push_req, ms_set, ls_set} <= 3'(1 << k);
      @(posedge clk_sys);
      {push_req, ms_set, ls_set} <= 3'h0;
      #1;
   endtask : cmd
   // priority model of the status byte; a reported transmit source is consumed
   task automatic chk_st();
      logic [3:0] c;
      c = (m_ien[2] && m_ls) ? 4'h6 : (m_ien[0] && m_tmo) ? 4'hc :
          (m_ien[0] && m_lvl >= m_trig) ? 4'h4 : (m_ien[1] && m_tx) ? 4'h2 :
          (m_ien[3] && m_ms) ? 4'h0 : 4'h1;
      `CHK("irq", c != 4'h1, irq)
      rd(UIC_OFS_ISTAT);
      `CHK("status", {{2{m_fen}}, 2'b00, c}, d)
      if (c == 4'h2) m_tx = 1'b0;
   endtask : chk_st
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // hang guard, far beyond the few hundred cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      end_sim();
   end
   initial
   begin
      {rst, reg_wr, reg_rd, tx_empty, ls_set, ms_set, push_req} = 7'h40;
      {reg_addr, reg_wdata, size_sel, m_ien, m_fen, m_ls, m_ms, m_tx, m_tmo} = '0;
      {err_total, compares, m_lvl, m_trig, seed} = {32'd0, 32'd0, 32'd0, 32'd1, 32'h4aae};
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      rd(UIC_OFS_ISTAT);
      `CHK("status_rst", 8'h01, d)
      rd(UIC_OFS_LFMT);
      `CHK("format_rst", 8'h00, d)
      // random formats, every parity combination once, break set in half of them
      for (int i = 0; i < 8; i++)
      begin
         v = 8'($random(seed));
         v[7:3] = {1'b0, i[0] ^ i[1], i[2:0]};
         wr(UIC_OFS_LFMT, v);
         `CHK("break", tx_line_in & ~v[6], tx_line_out)
         rd(UIC_OFS_LFMT);
         `CHK("format", v, d)
      end
      wr(UIC_OFS_LFMT, 8'h00);
      wr(UIC_OFS_ISTAT, 8'hc6);
      rd(UIC_OFS_ISTAT);
      `CHK("fifo_off", 8'h01, d)
      for (int t = 0; t < 16; t++)
      begin
         size_sel <= t[3:2];
         wr(UIC_OFS_ISTAT, {t[1:0], 6'h01});
         `CHK("trigger", 8'(tbl[t]), trig_level)
      end
      size_sel <= 2'h0;
      wr(UIC_OFS_ISTAT, 8'h47);
      {m_fen, m_trig} = {1'b1, 32'd4};
      wr(UIC_OFS_IEN, 8'h0f);
      m_ien = 4'hf;
      chk_st();
      cmd(1);
      m_ms = 1'b1;
      chk_st();
      tx_empty <= 1'b1;
      m_tx = 1'b1;
      chk_st();
      chk_st();
      repeat (4) cmd(2);
      m_lvl = 4;
      cmd(0);
      m_ls = 1'b1;
      chk_st();
      rd(UIC_OFS_LSTAT);
      m_ls = 1'b0;
      chk_st();
      rd(UIC_OFS_DATA);
      m_lvl = 3;
      chk_st();
      rd(UIC_OFS_MSTAT);
      m_ms = 1'b0;
      // 5-bit frame is 7 bits, so the time-out lands 40 bit times after the last receive data read
      repeat (100) @(posedge clk_sys);
      chk_st();
      repeat (60) @(posedge clk_sys);
      m_tmo = 1'b1;
      chk_st();
      rd(UIC_OFS_DATA);
      {m_tmo, m_lvl} = {1'b0, 32'd2};
      chk_st();
      repeat (2) rd(UIC_OFS_DATA);
      m_lvl = 0;
      tx_empty <= 1'b0;
      repeat (2) @(posedge clk_sys);
      tx_empty <= 1'b1;
      wr(UIC_OFS_DATA, 8'h5a);
      chk_st();
      wr(UIC_OFS_IEN, 8'h00);
      m_ien = 4'h0;
      cmd(1);
      m_ms = 1'b1;
      chk_st();
      wr(UIC_OFS_IEN, 8'h08);
      m_ien = 4'h8;
      chk_st();
      rd(UIC_OFS_MSTAT);
      m_ms = 1'b0;
      wr(UIC_OFS_ISTAT, 8'h01);
      m_trig = 1;
      m_ien = 4'h9;
      wr(UIC_OFS_IEN, 8'h09);
      repeat (2) cmd(2);
      m_lvl = 2;
      chk_st();
      wr(UIC_OFS_ISTAT, 8'h03);
      @(posedge clk_sys);
      #1 m_lvl = 0;
      chk_st();
      wr(UIC_OFS_LFMT, 8'h80);
      wr(UIC_OFS_DATA, 8'h12);
      wr(UIC_OFS_IEN, 8'h34);
      rd(UIC_OFS_DATA);
      wr(UIC_OFS_LFMT, 8'h00);
      rd(UIC_OFS_IEN);
      `CHK("ien_kept", 8'h09, d)
      rd(3'h7);
      `CHK("unmapped", 8'h00, d)
      end_sim();
   end
endmodule : uic_ctrl_tb
